// ### hdl/pso_top.sv
// Reference switchover, lock watch, source checks and output divider with APB registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pso_top #(
	parameter int unsigned LOSS_CYCLES = pso_pkg::PSO_LOSS_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Reference inputs and switch request
	input  wire logic        ref_clk_primary,
	input  wire logic        ref_clk_backup,
	input  wire logic        switch_req_n,
	// Status and clocks
	output logic             primary_ref_lost,
	output logic             backup_ref_lost,
	output logic             active_clk_backup,
	output logic             pll_locked,
	output logic             ref_out,
	output logic             post_scale_divider_first
);
	import pso_pkg::*;

	// ****************************************
	// Registers and decode
	// ****************************************
	pso_ctrl_t ctrl;
	pso_div_t  div;
	pso_lock_t lock;
	logic [31:0] status;
	logic [31:0] rd_mux;

	wire acc      = psel & penable & ~pready;
	wire wr_done  = psel & penable & pready & pwrite;
	wire hit_ctrl = paddr == PSO_OFS_CTRL;
	wire hit_div  = paddr == PSO_OFS_DIV;
	wire hit_lock = paddr == PSO_OFS_LOCK;
	wire hit_stat = paddr == PSO_OFS_STATUS;
	wire mapped   = hit_ctrl | hit_div | hit_lock | hit_stat;

	assign rd_mux = hit_ctrl ? {23'h000000, ctrl[8:0]} :
	                hit_div  ? {10'h000, div[21:0]} :
	                hit_lock ? lock :
	                hit_stat ? status : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~mapped;
			prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= PSO_RST_CTRL;
			div  <= PSO_RST_DIV;
			lock <= PSO_RST_LOCK;
		end else begin
			if (wr_done && hit_ctrl)
				ctrl <= {23'h000000, pwdata[8:0]};
			if (wr_done && hit_div)
				div <= {10'h000, pwdata[21:0]};
			if (wr_done && hit_lock)
				lock <= pwdata;
		end
	end

	// ****************************************
	// Source and chaining checks
	// ****************************************
	// Unsupported settings are only flagged; software is expected to fix them
	wire two_core    = ctrl.src_primary == PSO_SRC_CORE && ctrl.src_backup == PSO_SRC_CORE;
	wire two_cascade = ctrl.src_primary == PSO_SRC_CASCADE && ctrl.src_backup == PSO_SRC_CASCADE;
	wire bad_src     = ctrl.src_primary[1] & ctrl.src_primary[0] | ctrl.src_backup[1] & ctrl.src_backup[0];
	wire uses_casc   = ctrl.cascade_en | ctrl.src_primary == PSO_SRC_CASCADE | ctrl.src_backup == PSO_SRC_CASCADE;
	wire cfg_bad     = bad_src | two_core | two_cascade | (ctrl.frac_type & uses_casc);
	wire fb_duty_bad = ctrl.ext_feedback & ~ctrl.frac_type & (div.high != div.divide);

	// ****************************************
	// Clock sense
	// ****************************************
	logic p_lvl, p_rise, p_fall, p_lost;
	logic b_lvl, b_rise, b_fall, b_lost;

	pso_sense #(.LOSS_CYCLES(LOSS_CYCLES)) u_sense_primary (
		.pclk    (pclk),
		.presetn (presetn),
		.ref_clk (ref_clk_primary),
		.level   (p_lvl),
		.rise    (p_rise),
		.fall    (p_fall),
		.lost    (p_lost)
	);

	pso_sense #(.LOSS_CYCLES(LOSS_CYCLES)) u_sense_backup (
		.pclk    (pclk),
		.presetn (presetn),
		.ref_clk (ref_clk_backup),
		.level   (b_lvl),
		.rise    (b_rise),
		.fall    (b_fall),
		.lost    (b_lost)
	);

	// ****************************************
	// Switch request
	// ****************************************
	logic req_meta, req_s, req_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_meta <= 1'b1;
			req_s    <= 1'b1;
			req_d    <= 1'b1;
		end else begin
			req_meta <= switch_req_n;
			req_s    <= req_meta;
			req_d    <= req_s;
		end
	end

	wire req_fall = ~req_s & req_d;
	wire req_held = ~req_s & ~req_d;

	// ****************************************
	// Switchover state machine
	// ****************************************
	typedef enum logic [1:0] {PSO_ST_IDLE, PSO_ST_ARM, PSO_ST_GATE, PSO_ST_JOIN} pso_state_t;
	pso_state_t state, next_state;
	logic       sel, gate;
	logic [1:0] arm_cnt;

	wire is_manual   = ctrl.mode == PSO_MODE_MANUAL;
	wire is_override = ctrl.mode == PSO_MODE_OVERRIDE;
	wire cur_lost    = sel ? b_lost : p_lost;
	wire tgt_lost    = sel ? p_lost : b_lost;
	wire cur_fall    = sel ? b_fall : p_fall;
	wire tgt_fall    = sel ? p_fall : b_fall;
	wire tgt_rise    = sel ? p_rise : b_rise;
	wire cur_level   = sel ? b_lvl : p_lvl;
	wire auto_go     = ~is_manual & ~(is_override & ~req_s) & cur_lost & ~tgt_lost;
	wire force_go    = is_override & req_fall;
	// The first counted rise may follow the request at once, so one more rise makes three whole cycles
	wire arm_done    = tgt_rise & (arm_cnt == PSO_MAN_EDGES);

	always_comb begin
		next_state = state;
		unique case (state)
			PSO_ST_IDLE:
				if (is_manual && req_fall)
					next_state = PSO_ST_ARM;
				else if (force_go || auto_go)
					next_state = PSO_ST_GATE;
			PSO_ST_ARM:
				if (req_s)
					next_state = PSO_ST_IDLE;
				else if (arm_done)
					next_state = PSO_ST_GATE;
			// Gate closes on entry; wait for the old clock's low half, or go on at once if it is dead
			PSO_ST_GATE:
				if (cur_fall || cur_lost || !cur_level)
					next_state = PSO_ST_JOIN;
			// Join on a falling edge of the target so its next high is whole
			PSO_ST_JOIN:
				if (tgt_fall && !tgt_lost)
					next_state = PSO_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= PSO_ST_IDLE;
			sel     <= 1'b0;
			gate    <= 1'b1;
			arm_cnt <= 2'h0;
		end else begin
			state   <= next_state;
			arm_cnt <= (state == PSO_ST_ARM) ? arm_cnt + 2'(tgt_rise) : 2'h0;
			if (state != PSO_ST_GATE && next_state == PSO_ST_GATE)
				gate <= 1'b0;
			if (state == PSO_ST_JOIN && next_state == PSO_ST_IDLE) begin
				sel  <= ~sel;
				gate <= 1'b1;
			end
		end
	end

	// ****************************************
	// Lock watch and outputs
	// ****************************************
	// Period is measured in clock cycles between rises of the active reference
	logic [15:0] period_cnt;
	logic        in_range;
	wire         act_rise = sel ? b_rise : p_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= 16'h0000;
			in_range   <= 1'b0;
		end else begin
			period_cnt <= act_rise ? 16'h0001 : (period_cnt == 16'hffff ? period_cnt : period_cnt + 16'h0001);
			if (act_rise)
				in_range <= period_cnt >= lock.min_period && period_cnt <= lock.max_period;
			else if (cur_lost || period_cnt > lock.max_period)
				in_range <= 1'b0;
		end
	end

	assign status = {25'h0000000, state != PSO_ST_IDLE, fb_duty_bad, cfg_bad,
	                 pll_locked, active_clk_backup, backup_ref_lost, primary_ref_lost};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_ref_lost  <= 1'b0;
			backup_ref_lost   <= 1'b0;
			active_clk_backup <= 1'b0;
			pll_locked        <= 1'b0;
			ref_out           <= 1'b0;
		end else begin
			primary_ref_lost  <= p_lost;
			backup_ref_lost   <= b_lost;
			active_clk_backup <= sel;
			pll_locked        <= in_range & gate & ~cur_lost;
			ref_out           <= gate & cur_level;
		end
	end

	pso_divider u_divider (
		.pclk      (pclk),
		.presetn   (presetn),
		.cfg       (div),
		.frac_type (ctrl.frac_type),
		.clk_out   (post_scale_divider_first)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_after_access: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without access phase");
	a_swap_gated: assert property ($changed(active_clk_backup) |-> !ref_out && $past(gate, 2) == 1'b0)
		else $error("reference not gated across swap");
	a_manual_three: assert property (state == PSO_ST_GATE && $past(state) == PSO_ST_ARM |->
		$past(arm_cnt) == PSO_MAN_EDGES && $past(tgt_rise))
		else $error("manual swap before three target cycles");
	a_rise_no_swap: assert property (is_manual && state == PSO_ST_IDLE && req_s |=> state == PSO_ST_IDLE)
		else $error("swap started without falling request");
	a_override_hold: assert property (is_override && req_held && state == PSO_ST_IDLE |=> state == PSO_ST_IDLE)
		else $error("swap while override request held low");
	a_override_force: assert property (is_override && req_fall && state == PSO_ST_IDLE |=> state == PSO_ST_GATE)
		else $error("falling request did not force a swap");
	a_auto_switch: assert property (ctrl.mode == PSO_MODE_AUTO && state == PSO_ST_IDLE &&
		cur_lost && !tgt_lost |=> state == PSO_ST_GATE)
		else $error("lost reference not switched");
	a_wait_target: assert property (state == PSO_ST_JOIN && tgt_lost |=> $stable(sel))
		else $error("joined a dead target clock");
	a_lock_drop: assert property (!in_range |=> !pll_locked)
		else $error("locked while reference out of range");
	a_frac_no_chain: assert property (ctrl.frac_type && ctrl.cascade_en |-> status[4])
		else $error("fractional chaining not flagged");

	c_auto_swap: cover property (ctrl.mode == PSO_MODE_AUTO ##1 $changed(sel));
	c_manual_swap: cover property (is_manual && state == PSO_ST_JOIN ##1 state == PSO_ST_IDLE);
	c_override_swap: cover property (force_go ##[1:200] $changed(sel));
	c_locked: cover property ($rose(pll_locked));
endmodule
`default_nettype wire

// ### hdl/pso_pkg.sv
// Package with register map, field layout and timing constants of the switchover block
package pso_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] PSO_OFS_CTRL   = 8'h00;
	localparam logic [7:0] PSO_OFS_DIV    = 8'h04;
	localparam logic [7:0] PSO_OFS_LOCK   = 8'h08;
	localparam logic [7:0] PSO_OFS_STATUS = 8'h0c;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] PSO_RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] PSO_RST_DIV  = 32'h0000_0101;
	localparam logic [31:0] PSO_RST_LOCK = 32'hffff_0000;

	// ****************************************
	// Timing
	// ****************************************
	// Oscillator core period in clock cycles: one cycle is one eighth of it
	localparam int unsigned PSO_OSC_SUB      = 8;
	localparam int unsigned PSO_LOSS_CYCLES  = 16;
	localparam logic [1:0]  PSO_MAN_EDGES    = 2'h3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PSO_MODE_AUTO     = 2'h0,
		PSO_MODE_MANUAL   = 2'h1,
		PSO_MODE_OVERRIDE = 2'h2
	} pso_mode_t;

	typedef enum logic [1:0] {
		PSO_SRC_PIN     = 2'h0,
		PSO_SRC_CORE    = 2'h1,
		PSO_SRC_CASCADE = 2'h2
	} pso_src_t;

	typedef struct packed {
		logic [22:0] rsvd;
		pso_src_t    src_backup;
		pso_src_t    src_primary;
		logic        cascade_en;
		logic        ext_feedback;
		logic        frac_type;
		pso_mode_t   mode;
	} pso_ctrl_t;

	typedef struct packed {
		logic [9:0] rsvd;
		logic [5:0] phase;
		logic [7:0] high;
		logic [7:0] divide;
	} pso_div_t;

	typedef struct packed {
		logic [15:0] max_period;
		logic [15:0] min_period;
	} pso_lock_t;

endpackage

// ### hdl/pso_sense.sv
// Reference clock sense: synchroniser, edge detection and loss of toggling
`timescale 1ns/1ps
`default_nettype none
module pso_sense #(
	parameter int unsigned LOSS_CYCLES = pso_pkg::PSO_LOSS_CYCLES
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Reference pin
	input  wire logic ref_clk,
	// Sampled view
	output logic      level,
	output logic      rise,
	output logic      fall,
	output logic      lost
);
	import pso_pkg::*;

	logic       meta;
	logic       prev;
	logic [7:0] idle_cnt;
	wire        edge_seen = level ^ prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta  <= 1'b0;
			level <= 1'b0;
			prev  <= 1'b0;
		end else begin
			meta  <= ref_clk;
			level <= meta;
			prev  <= level;
		end
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;

	// Saturating idle counter: any edge proves the clock alive again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= 8'h00;
			lost     <= 1'b0;
		end else begin
			idle_cnt <= edge_seen ? 8'h00 : (idle_cnt == 8'hff ? idle_cnt : idle_cnt + 8'h01);
			lost     <= !edge_seen && (idle_cnt >= 8'(LOSS_CYCLES));
		end
	end
endmodule
`default_nettype wire

// ### hdl/pso_divider.sv
// Post-scale divider with phase offset and duty control
`timescale 1ns/1ps
`default_nettype none
module pso_divider (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Settings
	input  wire pso_pkg::pso_div_t cfg,
	input  wire logic         frac_type,
	// Output clock
	output logic              clk_out
);
	import pso_pkg::*;

	logic [10:0] pos;
	wire  [7:0]  div_eff = (cfg.divide == 8'h00) ? 8'h01 : cfg.divide;
	wire  [10:0] total   = {div_eff, 3'b000};
	// Fractional type steps a quarter period and keeps half duty
	wire  [10:0] ph      = frac_type ? {4'h0, cfg.phase, 1'b0} : {5'h00, cfg.phase};
	wire  [10:0] high_t  = frac_type ? {1'b0, div_eff, 2'b00} : {1'b0, cfg.high, 2'b00};
	wire  [10:0] shifted = (pos >= ph) ? pos - ph : pos + total - ph;
	wire  [10:0] next_pos = (pos >= total - 11'h001) ? 11'h000 : pos + 11'h001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos     <= 11'h000;
			clk_out <= 1'b0;
		end else begin
			pos     <= next_pos;
			clk_out <= shifted < high_t;
		end
	end

	a_frac_half_duty: assert property (@(posedge pclk) disable iff (!presetn)
		frac_type |-> (high_t == {1'b0, total[10:1]}))
		else $error("fractional type duty is not half");
endmodule
`default_nettype wire

// ### verification/pso_ref_src.sv
// Partner model: the two reference clock sources feeding the switchover block
`timescale 1ns/1ps
`default_nettype none
module pso_ref_src #(
	parameter int HALF_P = 5,
	parameter int HALF_B = 6
) (
	// Clock
	input  wire logic pclk,
	// Run controls
	input  wire logic run_primary,
	input  wire logic run_backup,
	// Reference pins
	output logic      ref_clk_primary = 1'b0,
	output logic      ref_clk_backup = 1'b0
);
	int cnt_p = 0;
	int cnt_b = 0;

	// Only two pin sources are supplied; a stopped source rests low like a dead oscillator
	// Plain oscillators, no upstream PLL: no chain and no bandwidth pairing arise
	always_ff @(posedge pclk) begin
		cnt_p <= (!run_primary || cnt_p == HALF_P - 1) ? 0 : cnt_p + 1;
		cnt_b <= (!run_backup || cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
		ref_clk_primary <= run_primary && (ref_clk_primary ^ (cnt_p == HALF_P - 1));
		ref_clk_backup <= run_backup && (ref_clk_backup ^ (cnt_b == HALF_B - 1));
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the reference switchover block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pso_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        run_p;
	logic        run_b;
	logic        switch_req_n;
	logic        rcp;
	logic        rcb;
	logic        lost_p;
	logic        lost_b;
	logic        act_b;
	logic        locked;
	logic        ref_out;
	logic        div_out;
	wire  [4:0]  st = {ref_out, locked, act_b, lost_b, lost_p};
	int          err_total;
	int          tests_run;

	pso_ref_src u_src (.pclk(pclk), .run_primary(run_p), .run_backup(run_b),
		.ref_clk_primary(rcp), .ref_clk_backup(rcb));

	pso_top #(.LOSS_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_clk_primary(rcp), .ref_clk_backup(rcb), .switch_req_n(switch_req_n),
		.primary_ref_lost(lost_p), .backup_ref_lost(lost_b), .active_clk_backup(act_b),
		.pll_locked(locked), .ref_out(ref_out), .post_scale_divider_first(div_out));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Holds the whole request until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, exp, r);
		chk(nm, {31'h0, eexp}, {31'h0, e});
	endtask

	task automatic stat_bit(input string nm, input int b, input logic exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, PSO_OFS_STATUS, 32'h0, r, e);
		chk(nm, {31'h0, exp}, {31'h0, r[b]});
	endtask

	// Bounded wait: running out of cycles ends the run
	task automatic wait_on(input int b, input logic v, input int n, input string nm);
		for (int i = 0; i < n && st[b] !== v; i++) @(posedge pclk);
		chk(nm, {31'h0, v}, {31'h0, st[b]});
		if (st[b] !== v) complete_run();
	endtask

	task automatic hold_on(input int b, input logic v, input int n, input string nm);
		for (int i = 0; i < n && st[b] === v; i++) @(posedge pclk);
		chk(nm, {31'h0, v}, {31'h0, st[b]});
	endtask

	task automatic measure(output int hi, output int per);
		for (int i = 0; i < 300 && div_out === 1'b1; i++) @(posedge pclk);
		for (int i = 0; i < 300 && div_out !== 1'b1; i++) @(posedge pclk);
		for (hi = 0; hi < 300 && div_out === 1'b1; hi++) @(posedge pclk);
		for (per = hi; per < 600 && div_out !== 1'b1; per++) @(posedge pclk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rd_chk("ctrl_rst", PSO_OFS_CTRL, PSO_RST_CTRL, 1'b0);
		rd_chk("div_rst", PSO_OFS_DIV, PSO_RST_DIV, 1'b0);
		rd_chk("lock_rst", PSO_OFS_LOCK, PSO_RST_LOCK, 1'b0);
		rd_chk("unmapped", 8'h10, 32'h0, 1'b1);
		wr(PSO_OFS_STATUS, 32'hffff_ffff);
		// Reset lock range spans every period, so only the lock bit reads back
		rd_chk("status_ro", PSO_OFS_STATUS, 32'h0000_0008, 1'b0);
	endtask

	task automatic t_manual();
		wr(PSO_OFS_CTRL, 32'h1);
		hold_on(2, 1'b0, 40, "man_start");
		switch_req_n <= 1'b0;
		// Shorter than three backup periods, then released
		repeat (12) @(posedge pclk);
		switch_req_n <= 1'b1;
		hold_on(2, 1'b0, 60, "man_short");
		switch_req_n <= 1'b0;
		hold_on(2, 1'b0, 24, "man_early");
		wait_on(2, 1'b1, 100, "man_swap");
		switch_req_n <= 1'b1;
		hold_on(2, 1'b1, 80, "man_rise");
	endtask

	task automatic t_auto();
		wr(PSO_OFS_CTRL, 32'h0);
		run_b <= 1'b0;
		wait_on(1, 1'b1, 60, "lost_b");
		wait_on(2, 1'b0, 80, "auto_swap");
		chk("lost_p", 32'h0, {31'h0, lost_p});
		run_b <= 1'b1;
		wait_on(1, 1'b0, 40, "lost_b_clr");
	endtask

	task automatic t_over();
		wr(PSO_OFS_CTRL, 32'h2);
		run_b <= 1'b0;
		wait_on(1, 1'b1, 60, "ovr_lost");
		switch_req_n <= 1'b0;
		hold_on(2, 1'b0, 60, "ovr_wait");
		hold_on(4, 1'b0, 12, "ovr_gated");
		run_b <= 1'b1;
		wait_on(2, 1'b1, 80, "ovr_swap");
		run_b <= 1'b0;
		hold_on(2, 1'b1, 80, "ovr_block");
		switch_req_n <= 1'b1;
		wait_on(2, 1'b0, 80, "ovr_auto");
		run_b <= 1'b1;
		wait_on(1, 1'b0, 40, "ovr_clr");
		wait_on(4, 1'b1, 40, "ref_live");
	endtask

	task automatic t_lock();
		wr(PSO_OFS_LOCK, 32'h000b_0009);
		wait_on(3, 1'b1, 200, "locked");
		wr(PSO_OFS_LOCK, 32'h001e_0014);
		wait_on(3, 1'b0, 60, "unlocked");
		run_p <= 1'b0;
		wait_on(0, 1'b1, 60, "lost_p_set");
		wait_on(2, 1'b1, 80, "auto_to_b");
		run_p <= 1'b1;
		wait_on(0, 1'b0, 40, "lost_p_clr");
	endtask

	task automatic t_div();
		int hi;
		int per;
		wr(PSO_OFS_DIV, 32'h0000_0102);
		measure(hi, per);
		measure(hi, per);
		chk("int_high", 32'd4, hi);
		chk("int_per", 32'd16, per);
		wr(PSO_OFS_DIV, 32'h0000_0302);
		measure(hi, per);
		measure(hi, per);
		chk("int_high3", 32'd12, hi);
		wr(PSO_OFS_CTRL, 32'h4);
		measure(hi, per);
		measure(hi, per);
		chk("frac_high", 32'd8, hi);
		chk("frac_per", 32'd16, per);
	endtask

	task automatic t_cfg();
		wr(PSO_OFS_CTRL, 32'h14);
		stat_bit("frac_chain", 4, 1'b1);
		wr(PSO_OFS_CTRL, 32'h50);
		stat_bit("int_chain", 4, 1'b0);
		wr(PSO_OFS_CTRL, 32'h20);
		stat_bit("src_core", 4, 1'b0);
		wr(PSO_OFS_CTRL, 32'h60);
		stat_bit("src_bad", 4, 1'b1);
		wr(PSO_OFS_CTRL, 32'ha0);
		stat_bit("two_core", 4, 1'b1);
		wr(PSO_OFS_CTRL, 32'h08);
		stat_bit("ext_fb", 5, 1'b1);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		run_p = 1'b1;
		run_b = 1'b1;
		switch_req_n = 1'b1;
		err_total = 0;
		tests_run = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_regs();
		t_manual();
		t_auto();
		t_over();
		t_lock();
		t_div();
		t_cfg();
		complete_run();
	end
endmodule
`default_nettype wire
